// File: design/ppes_params.svh
// Constants for the port pull-up and edge-select block
`ifndef PPES_PARAMS_SVH
`define PPES_PARAMS_SVH

`define PPES_SUB_PULLUP    8'h06
`define PPES_SUB_EDGE      8'h08
`define PPES_PULLUP_RESET  8'h00
`define PPES_EDGE_RESET    4'h0
`define PPES_SUB_RESET     8'h00
`define PPES_READ_ZERO     8'h00
`define PPES_EDGE_BITS     4
`define PPES_PINS          8

`endif

// File: design/ppes_pkg.sv
// Types shared by the port pull-up and edge-select block
`default_nettype none

package ppes_pkg;
    typedef logic [7:0] ppes_byte_t;
endpackage : ppes_pkg

`default_nettype wire

// File: design/ppes_edge_det.sv
// One interrupt pin: two-stage synchroniser and selectable edge detector
`default_nettype none

module ppes_edge_det (
    // Clock and reset
    input  wire logic i_clock,
    input  wire logic i_resetn,
    // Pin and selection
    input  wire logic i_pin,
    input  wire logic i_rising,
    // Request
    output var  logic o_req
);
    logic meta_q, meta_d;
    logic sync_q, sync_d;
    logic prev_q, prev_d;
    logic req_q,  req_d;

    always_comb begin
        meta_d = i_pin;
        sync_d = meta_q;
        prev_d = sync_q;
        // Rising when selected, else falling
        req_d  = i_rising ? (sync_q & ~prev_q) : (~sync_q & prev_q);
    end

    always_ff @(posedge i_clock) begin
        if (!i_resetn) begin
            meta_q <= 1'b0;
            sync_q <= 1'b0;
            prev_q <= 1'b0;
            req_q  <= 1'b0;
        end else begin
            meta_q <= meta_d;
            sync_q <= sync_d;
            prev_q <= prev_d;
            req_q  <= req_d;
        end
    end

    assign o_req = req_q;
endmodule : ppes_edge_det

`default_nettype wire

// File: design/ppes_top.sv
// Port pull-up enable and Port A interrupt edge-select subregisters
//
// How it works
// - Writing sub-address 06H to the address register maps control-register accesses to the pull-up bits.
// - The pull-up subregister holds one bit per pin in bits 7 to 0, each for its own pin.
// - A pull-up bit of 0 keeps that pin's weak pull-up off and 1 turns it on.
// - Each set pull-up bit drives its pin's weak pull-up enable output to the pad.
// - The edge-select bits decide the edge at which each Port A interrupt input requests.
// - With sub-address 08H in the address register, control accesses reach the edge-select bits.
// - Edge-select bits 3 to 0 are read-write and bits 7 to 4 read as zero and ignore writes.
// - An edge-select bit of 0 requests on a falling pin edge and 1 on a rising edge.
`include "ppes_params.svh"
`default_nettype none

module ppes_top #(
    parameter int PINS      = `PPES_PINS,
    parameter int EDGE_BITS = `PPES_EDGE_BITS
) (
    // Clock and reset
    input  wire logic                 i_clock,
    input  wire logic                 i_resetn,
    // Port address register access
    input  wire logic                 i_addr_wr,
    input  wire logic [7:0]           i_addr_wdata,
    // Port control register access and address register readback
    input  wire logic                 i_ctl_wr,
    input  wire logic [7:0]           i_ctl_wdata,
    output var  logic [7:0]           o_ctl_rdata,
    output var  logic [7:0]           o_addr_rdata,
    // Pads and interrupt pins
    output var  logic [PINS-1:0]      o_pullup_on_bits,
    input  wire logic [EDGE_BITS-1:0] i_first_port_pin_n,
    output var  logic [EDGE_BITS-1:0] o_irq_req
);
    // ****************************************
    // Subregister state
    // ****************************************
    ppes_pkg::ppes_byte_t     sub_addr_q, sub_addr_d;
    logic [PINS-1:0]          pullup_q, pullup_d;
    logic [EDGE_BITS-1:0]     edge_q, edge_d;
    ppes_pkg::ppes_byte_t     rdata_q, rdata_d;
    logic                     sel_pullup;
    logic                     sel_edge;

    always_comb begin
        sel_pullup = (sub_addr_q == `PPES_SUB_PULLUP);
        sel_edge   = (sub_addr_q == `PPES_SUB_EDGE);
        sub_addr_d = i_addr_wr ? i_addr_wdata : sub_addr_q;
        pullup_d   = pullup_q;
        edge_d     = edge_q;
        if (i_ctl_wr && sel_pullup) begin
            pullup_d = i_ctl_wdata[PINS-1:0];
        end
        if (i_ctl_wr && sel_edge) begin
            edge_d = i_ctl_wdata[EDGE_BITS-1:0];
        end
        // Read data follows the current sub-address; others read zero
        rdata_d = `PPES_READ_ZERO;
        if (sel_pullup) begin
            rdata_d = 8'(pullup_q);
        end else if (sel_edge) begin
            rdata_d = 8'(edge_q);
        end
    end

    always_ff @(posedge i_clock) begin
        if (!i_resetn) begin
            sub_addr_q <= `PPES_SUB_RESET;
            pullup_q   <= `PPES_PULLUP_RESET;
            edge_q     <= `PPES_EDGE_RESET;
            rdata_q    <= `PPES_READ_ZERO;
        end else begin
            sub_addr_q <= sub_addr_d;
            pullup_q   <= pullup_d;
            edge_q     <= edge_d;
            rdata_q    <= rdata_d;
        end
    end

    assign o_ctl_rdata      = rdata_q;
    assign o_addr_rdata     = sub_addr_q;
    // Register drives the pad enables directly, no glitches
    assign o_pullup_on_bits = pullup_q;

    // ****************************************
    // Edge detectors
    // ****************************************
    for (genvar g = 0; g < EDGE_BITS; g++) begin : g_edge
        ppes_edge_det u_det (
            .i_clock  (i_clock),
            .i_resetn (i_resetn),
            .i_pin    (i_first_port_pin_n[g]),
            .i_rising (edge_q[g]),
            .o_req    (o_irq_req[g])
        );
    end

    // ****************************************
    // Checks
    // ****************************************
    default clocking cb @(posedge i_clock);
    endclocking
    default disable iff (!i_resetn);

    chk_pullup_write: assert property (
        i_ctl_wr && sel_pullup |=> o_pullup_on_bits == $past(i_ctl_wdata[PINS-1:0]))
        else $error("pull-up write not taken");
    chk_pullup_hold: assert property (
        !(i_ctl_wr && sel_pullup) |=> $stable(o_pullup_on_bits))
        else $error("pull-up bits changed without write");
    chk_edge_write: assert property (
        i_ctl_wr && sel_edge |=> edge_q == $past(i_ctl_wdata[EDGE_BITS-1:0]))
        else $error("edge-select write not taken");
    chk_edge_upper: assert property (
        sel_edge && !i_addr_wr |=> o_ctl_rdata[7:4] == 4'h0)
        else $error("edge-select upper bits not zero");
    chk_pull_read: assert property (
        sel_pullup |=> o_ctl_rdata == $past(pullup_q))
        else $error("pull-up readback wrong");
    chk_rise_req: assert property (
        $rose(i_first_port_pin_n[0]) && edge_q[0] ##1 edge_q[0][*3] |-> o_irq_req[0])
        else $error("rising edge not requested");
    chk_fall_req: assert property (
        $fell(i_first_port_pin_n[0]) && !edge_q[0] ##1 !edge_q[0][*3] |-> o_irq_req[0])
        else $error("falling edge not requested");
    chk_req_pulse: assert property (
        o_irq_req[0] |=> !o_irq_req[0])
        else $error("request longer than one cycle");
    chk_edge_other: assert property (
        $stable(i_first_port_pin_n[1])[*4] ##1 1'b1 |-> !o_irq_req[1])
        else $error("request without pin edge");

    // ****************************************
    // Register map checks
    // ****************************************
    // Two edges from write to read: one into the subregister, one into the read register
    chk_pull_readback: assert property (
        i_ctl_wr && sel_pullup && !i_addr_wr
        |-> ##2 o_ctl_rdata[PINS-1:0] == $past(i_ctl_wdata[PINS-1:0], 2))
        else $error("pull-up write not read back");
    chk_edge_readback: assert property (
        i_ctl_wr && sel_edge && !i_addr_wr
        |-> ##2 o_ctl_rdata == 8'($past(i_ctl_wdata[EDGE_BITS-1:0], 2)))
        else $error("edge-select write not read back");
    chk_edge_read: assert property (
        sel_edge |=> o_ctl_rdata[EDGE_BITS-1:0] == $past(edge_q))
        else $error("edge-select readback wrong");
    chk_edge_hold: assert property (
        !(i_ctl_wr && sel_edge) |=> $stable(edge_q))
        else $error("edge-select bits changed without write");
    chk_other_read: assert property (
        !sel_pullup && !sel_edge |=> o_ctl_rdata == `PPES_READ_ZERO)
        else $error("unmapped sub-address not read as zero");
    // Writes to one subregister must leave the other alone
    chk_edge_sel_only: assert property (
        i_ctl_wr && sel_edge |=> $stable(o_pullup_on_bits))
        else $error("edge-select write disturbed pull-ups");
    chk_pull_sel_only: assert property (
        i_ctl_wr && sel_pullup |=> $stable(edge_q))
        else $error("pull-up write disturbed edge-select");
    chk_addr_write: assert property (
        i_addr_wr |=> o_addr_rdata == $past(i_addr_wdata))
        else $error("sub-address write not taken");
    chk_addr_hold: assert property (
        !i_addr_wr |=> $stable(o_addr_rdata))
        else $error("sub-address changed without write");
    // Reset is the antecedent here, so the default disable is lifted
    chk_reset_state: assert property (
        disable iff (1'b0)
        !i_resetn |=> o_pullup_on_bits == `PPES_PULLUP_RESET && o_irq_req == '0
                      && o_ctl_rdata == `PPES_READ_ZERO)
        else $error("outputs not cleared by reset");

    // ****************************************
    // Request checks
    // ****************************************
    // Select held over the pipeline; a change mid-flight takes the new select
    chk_rise_req1: assert property (
        $rose(i_first_port_pin_n[1]) && edge_q[1] ##1 edge_q[1][*3] |-> o_irq_req[1])
        else $error("rising edge not requested");
    chk_fall_req1: assert property (
        $fell(i_first_port_pin_n[1]) && !edge_q[1] ##1 !edge_q[1][*3] |-> o_irq_req[1])
        else $error("falling edge not requested");
    chk_rise_req2: assert property (
        $rose(i_first_port_pin_n[2]) && edge_q[2] ##1 edge_q[2][*3] |-> o_irq_req[2])
        else $error("rising edge not requested");
    chk_fall_req2: assert property (
        $fell(i_first_port_pin_n[2]) && !edge_q[2] ##1 !edge_q[2][*3] |-> o_irq_req[2])
        else $error("falling edge not requested");
    chk_rise_req3: assert property (
        $rose(i_first_port_pin_n[3]) && edge_q[3] ##1 edge_q[3][*3] |-> o_irq_req[3])
        else $error("rising edge not requested");
    chk_fall_req3: assert property (
        $fell(i_first_port_pin_n[3]) && !edge_q[3] ##1 !edge_q[3][*3] |-> o_irq_req[3])
        else $error("falling edge not requested");

    chk_pulse_pin1: assert property (
        o_irq_req[1] |=> !o_irq_req[1])
        else $error("request longer than one cycle");
    chk_pulse_pin2: assert property (
        o_irq_req[2] |=> !o_irq_req[2])
        else $error("request longer than one cycle");
    chk_pulse_pin3: assert property (
        o_irq_req[3] |=> !o_irq_req[3])
        else $error("request longer than one cycle");
    // Four steady samples leave the detector pipeline empty
    chk_quiet_pin0: assert property (
        $stable(i_first_port_pin_n[0])[*4] ##1 1'b1 |-> !o_irq_req[0])
        else $error("request without pin edge");
    chk_quiet_pin2: assert property (
        $stable(i_first_port_pin_n[2])[*4] ##1 1'b1 |-> !o_irq_req[2])
        else $error("request without pin edge");
    chk_quiet_pin3: assert property (
        $stable(i_first_port_pin_n[3])[*4] ##1 1'b1 |-> !o_irq_req[3])
        else $error("request without pin edge");

    // ****************************************
    // Coverage
    // ****************************************
    cov_pull_write: cover property (i_ctl_wr && sel_pullup);
    cov_edge_write: cover property (i_ctl_wr && sel_edge);
    cov_rise: cover property (edge_q[0] && o_irq_req[0]);
    cov_fall: cover property (!edge_q[0] && o_irq_req[0]);
    cov_other_write: cover property (i_ctl_wr && !sel_pullup && !sel_edge);
endmodule : ppes_top

`default_nettype wire

// File: verif/ppes_pin_model.sv
// Outside drivers of the Port A interrupt pins
`default_nettype none
module ppes_pin_model (
    // Clock
    input  wire logic       i_clock,
    // Level asked for by the bench
    input  wire logic [3:0] i_level,
    // Pins
    output var  logic [3:0] o_pin
);
    timeunit 1ns;
    timeprecision 1ps;
    // Driven hard at all times, so no released level to model
    initial o_pin = 4'h0;
    always @(posedge i_clock) begin
        o_pin <= #1 i_level;
    end
endmodule : ppes_pin_model
`default_nettype wire

// File: verif/tb_top.sv
// Self-checking bench for the pull-up and edge-select block
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic       i_clock      = 1'b0;
    logic       i_resetn     = 1'b0;
    logic       i_addr_wr    = 1'b0;
    logic       i_ctl_wr     = 1'b0;
    logic [7:0] i_addr_wdata = 8'h00;
    logic [7:0] i_ctl_wdata  = 8'h00;
    logic [3:0] lvl          = 4'h0;
    logic [3:0] pins;
    logic [3:0] irq;
    logic [7:0] rdata;
    logic [7:0] pull;
    logic [7:0] addr_rd;
    int         fail_count   = 0;
    int         n_tests      = 0;
    always #4 i_clock = ~i_clock;
    ppes_top ppes_top_i (.i_clock(i_clock), .i_resetn(i_resetn), .i_addr_wr(i_addr_wr),
        .i_addr_wdata(i_addr_wdata), .i_ctl_wr(i_ctl_wr), .i_ctl_wdata(i_ctl_wdata),
        .o_ctl_rdata(rdata), .o_addr_rdata(addr_rd), .o_pullup_on_bits(pull),
        .i_first_port_pin_n(pins), .o_irq_req(irq));
    ppes_pin_model ppes_pin_model_i (.i_clock(i_clock), .i_level(lvl), .o_pin(pins));
    // ************
    // Tasks
    // ************
    task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
        n_tests++;
        if (got !== exp) begin
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
            fail_count++;
        end
    endtask : chk
    task automatic finish_test();
        if (fail_count == 0 && n_tests > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : finish_test
    // Address then data, then two edges for the registered read
    task automatic wr_sub(input logic [7:0] sub, input logic [7:0] data);
        @(posedge i_clock) #1;
        i_addr_wr = 1'b1;
        i_addr_wdata = sub;
        @(posedge i_clock) #1;
        i_addr_wr = 1'b0;
        i_ctl_wr = 1'b1;
        i_ctl_wdata = data;
        @(posedge i_clock) #1;
        i_ctl_wr = 1'b0;
        repeat (2) @(posedge i_clock);
        #1;
        chk("addr_read", sub, addr_rd);
    endtask : wr_sub
    task automatic edge_case(input logic [3:0] to, input logic [3:0] exp);
        int n;
        n = 0;
        lvl = to;
        while (irq === 4'h0 && n < 8) begin
            @(posedge i_clock) #1;
            n++;
        end
        if (irq === 4'h0) begin
            fail_count++;
            finish_test();
        end
        chk("irq_req", {4'h0, exp}, {4'h0, irq});
        @(posedge i_clock) #1;
        chk("irq_req_end", 8'h00, {4'h0, irq});
    endtask : edge_case
    task automatic test_reset();
        repeat (6) @(posedge i_clock);
        #1;
        chk("reset_pull", 8'h00, pull);
        chk("reset_irq", 8'h00, {4'h0, irq});
        chk("reset_read", 8'h00, rdata);
        chk("reset_addr", 8'h00, addr_rd);
        i_resetn = 1'b1;
    endtask : test_reset
    task automatic test_pullup();
        wr_sub(8'h06, 8'ha5);
        chk("pull_pads", 8'ha5, pull);
        chk("pull_read", 8'ha5, rdata);
    endtask : test_pullup
    task automatic test_edge_regs();
        wr_sub(8'h08, 8'hff);
        chk("edge_read", 8'h0f, rdata);
        chk("pull_kept", 8'ha5, pull);
    endtask : test_edge_regs
    task automatic test_other_sub();
        wr_sub(8'h07, 8'h3c);
        chk("other_read", 8'h00, rdata);
        chk("pull_kept2", 8'ha5, pull);
    endtask : test_other_sub
    // Each pin sees both edges under both selects
    task automatic test_edges();
        wr_sub(8'h08, 8'h05);
        chk("edge_read2", 8'h05, rdata);
        edge_case(4'hf, 4'h5);
        edge_case(4'h0, 4'ha);
        wr_sub(8'h08, 8'h0a);
        chk("edge_read3", 8'h0a, rdata);
        edge_case(4'hf, 4'ha);
        edge_case(4'h0, 4'h5);
    endtask : test_edges
    task automatic test_pullup2();
        wr_sub(8'h06, 8'h5a);
        chk("pull_pads2", 8'h5a, pull);
    endtask : test_pullup2
    initial begin
        test_reset();
        test_pullup();
        test_edge_regs();
        test_other_sub();
        test_edges();
        test_pullup2();
        finish_test();
    end
endmodule : tb_top
`default_nettype wire
